// ---- hw/adc_mode_params.svh ----
`ifndef ADC_MODE_PARAMS_SVH
`define ADC_MODE_PARAMS_SVH

// serial frame geometry
`define MC_WORD_W 16
`define MC_FRAME_BITS 5'h10
`define MC_LAST_BIT 5'h0f
`define MC_COUNT_W 5

// field positions inside the mode control word
`define MC_SEL_BIT 15
`define MC_SCAN_HI 14
`define MC_SCAN_LO 11
`define MC_CHAN_HI 10
`define MC_CHAN_LO 7
`define MC_CLR_HI 6
`define MC_CLR_LO 5
`define MC_PM_HI 4
`define MC_PM_LO 3
`define MC_TAG_BIT 2
`define MC_SWC_BIT 1

// value of the register select bit that addresses the mode control word
`define MC_SEL_MODE 1'h0

// scan codes
`define SCAN_KEEP 4'h0
`define SCAN_MANUAL 4'h1
`define SCAN_REPEAT 4'h2
`define SCAN_STD_INT 4'h3
`define SCAN_STD_EXT 4'h4
`define SCAN_UPPER_INT 4'h5
`define SCAN_UPPER_EXT 4'h6
`define SCAN_CUSTOM_INT 4'h7
`define SCAN_CUSTOM_EXT 4'h8
`define SCAN_SEQ_EXT 4'h9

// clear field codes
`define CLR_NONE 2'h0
`define CLR_FIFO 2'h1
`define CLR_ALL 2'h2

// reset defaults
`define SCAN_DEFAULT 4'h1
`define CHAN_DEFAULT 4'h0
`define PM_DEFAULT 2'h0
`define TAG_DEFAULT 1'h0
`define SWC_DEFAULT 1'h0
`define CHAN_ZERO 4'h0
`define CHAN_TOP 4'hf

// result word geometry
`define RESULT_W 12
`define CHAN_W 4
`define TAG_PAD 4'h0

`endif

// ---- hw/adc_mode_pkg.sv ----
`include "adc_mode_params.svh"

package adc_mode_pkg;

  typedef enum logic {
    CLOCK_EXTERNAL,
    CLOCK_INTERNAL
  } clock_mode_t;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_BUSY
  } conv_state_t;

  typedef struct packed {
    logic [3:0] scan_code;
    logic [`CHAN_W-1:0] input_channel_number;
    logic [1:0] power_state_field;
    logic output_tag_enable;
    logic software_convert_trigger;
  } mode_ctrl_t;

  typedef struct packed {
    logic [`CHAN_W-1:0] first_channel;
    logic [`CHAN_W-1:0] last_channel;
    logic fifo_used;
    logic averaging_ok;
  } scan_plan_t;

endpackage : adc_mode_pkg

// ---- hw/serial_word_rx.sv ----
`timescale 1ns/1ps
`include "adc_mode_params.svh"

module serial_word_rx (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic reset_i,
  output logic [`MC_WORD_W-1:0] word_o,
  output logic word_toggle_o
);

  logic [`MC_COUNT_W-1:0] count_reg;
  logic [`MC_COUNT_W-1:0] count_next;
  logic [`MC_WORD_W-2:0] shift_reg;
  logic [`MC_WORD_W-2:0] shift_next;
  logic [`MC_WORD_W-1:0] word_reg;
  logic [`MC_WORD_W-1:0] word_next;
  logic toggle_reg;
  logic toggle_next;

  // shift msb first; the word is published only on the sixteenth bit
  always_comb begin
    count_next = count_reg;
    shift_next = shift_reg;
    word_next = word_reg;
    toggle_next = toggle_reg;
    if (count_reg != `MC_FRAME_BITS) begin
      count_next = count_reg + `MC_COUNT_W'(1);
      shift_next = {shift_reg[`MC_WORD_W-3:0], din_i};
    end
    if (count_reg == `MC_LAST_BIT) begin
      word_next = {shift_reg, din_i};
      toggle_next = ~toggle_reg;
    end
  end

  // the bit counter is cleared asynchronously by chip select, since sclk stops between frames
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge reset_i) begin
    if (cs_n_i || reset_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // word and toggle survive across frames; word stays stable until the next toggle
  always_ff @(posedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= '0;
      word_reg <= '0;
      toggle_reg <= 1'h0;
    end else begin
      shift_reg <= shift_next;
      word_reg <= word_next;
      toggle_reg <= toggle_next;
    end
  end

  assign word_o = word_reg;
  assign word_toggle_o = toggle_reg;

endmodule : serial_word_rx

// ---- hw/adc_mode_control_decode.sv ----
`timescale 1ns/1ps
`include "adc_mode_params.svh"

// Contract
// - bit 15 zero selects mode control word
// - bits 10:7 hold channel, default zero
// - clear code 01 clears FIFO only
// - clear code 10 restores defaults, empties FIFO
// - bits 4:3 choose power state, default zero
// - tag bit gives 4-bit channel plus result
// - internal clock always tags output words
// - software convert starts on chip-select rise; here in internal clock mode only
// - device clears convert bit after conversion
// - scan code zero keeps scan settings
// - scan code zero still updates clear, power, convert
// - code 0001 manual, default, no FIFO
// - manual mode uses external clock only
// - code 0010 repeats channel N into FIFO
// - repeat mode uses internal clock only
// - code 0011 scans 0 to N internally
module adc_mode_control_decode
  import adc_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic convert_start_pin_n_i,
  input wire logic conv_done_i,
  input wire logic result_valid_i,
  input wire logic [`CHAN_W-1:0] result_chan_i,
  input wire logic [`RESULT_W-1:0] result_data_i,
  output mode_ctrl_t mode_o,
  output clock_mode_t clock_mode_o,
  output logic output_tag_enable_o,
  output scan_plan_t scan_plan_o,
  output logic fifo_clear_o,
  output logic full_reset_o,
  output logic conv_start_o,
  output logic conv_busy_o,
  output logic config_write_o,
  output logic [`MC_WORD_W-1:0] config_word_o,
  output logic [`MC_WORD_W-1:0] out_word_o,
  output logic out_word_valid_o
);

  logic [`MC_WORD_W-1:0] rx_word;
  logic rx_toggle;

  // link side: shifts the frame on sclk and hands over a held word plus a toggle
  serial_word_rx rx (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .reset_i(reset_i),
    .word_o(rx_word),
    .word_toggle_o(rx_toggle)
  );

  // synchronisers: the first stage of each is read only by the second
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_last_reg;
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_last_reg;
  logic cnv_meta_reg;
  logic cnv_sync_reg;
  logic cnv_last_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tog_meta_reg <= 1'h0;
      tog_sync_reg <= 1'h0;
      tog_last_reg <= 1'h0;
      cs_meta_reg <= 1'h1;
      cs_sync_reg <= 1'h1;
      cs_last_reg <= 1'h1;
      cnv_meta_reg <= 1'h1;
      cnv_sync_reg <= 1'h1;
      cnv_last_reg <= 1'h1;
    end else begin
      tog_meta_reg <= rx_toggle;
      tog_sync_reg <= tog_meta_reg;
      tog_last_reg <= tog_sync_reg;
      cs_meta_reg <= cs_n_i;
      cs_sync_reg <= cs_meta_reg;
      cs_last_reg <= cs_sync_reg;
      cnv_meta_reg <= convert_start_pin_n_i;
      cnv_sync_reg <= cnv_meta_reg;
      cnv_last_reg <= cnv_sync_reg;
    end
  end

  logic word_arrived;
  logic cs_rise;
  logic cnv_fall;

  // the held word is safe to read here: it changes at most once per 16 sclk periods
  assign word_arrived = tog_sync_reg != tog_last_reg;
  assign cs_rise = cs_sync_reg && !cs_last_reg;
  assign cnv_fall = !cnv_sync_reg && cnv_last_reg;

  // mode control state
  mode_ctrl_t mode_reg;
  mode_ctrl_t mode_next;
  logic fifo_clear_reg;
  logic fifo_clear_next;
  logic full_reset_reg;
  logic full_reset_next;
  logic config_write_reg;
  logic config_write_next;
  logic [`MC_WORD_W-1:0] config_word_reg;
  logic [`MC_WORD_W-1:0] config_word_next;
  conv_state_t conv_state_reg;
  conv_state_t conv_state_next;
  logic conv_start_reg;
  logic conv_start_next;
  logic sw_done;

  logic [3:0] wr_scan;
  logic [1:0] wr_clear;
  logic scan_kept;

  assign wr_scan = rx_word[`MC_SCAN_HI:`MC_SCAN_LO];
  assign wr_clear = rx_word[`MC_CLR_HI:`MC_CLR_LO];
  // codes above the sequence mode behave like code zero
  assign scan_kept = (wr_scan == `SCAN_KEEP) || (wr_scan > `SCAN_SEQ_EXT);

  // the convert bit falls once a software-started conversion finishes
  assign sw_done = conv_done_i && (conv_state_reg == CONV_BUSY)
                   && mode_reg.software_convert_trigger;

  // decode a finished word; a new write of the convert bit wins over its clear
  always_comb begin
    mode_next = mode_reg;
    fifo_clear_next = 1'h0;
    full_reset_next = 1'h0;
    config_write_next = 1'h0;
    config_word_next = config_word_reg;
    if (sw_done) begin
      mode_next.software_convert_trigger = 1'h0;
    end
    if (word_arrived) begin
      if (rx_word[`MC_SEL_BIT] == `MC_SEL_MODE) begin
        if (wr_clear == `CLR_ALL) begin
          mode_next.scan_code = `SCAN_DEFAULT;
          mode_next.input_channel_number = `CHAN_DEFAULT;
          mode_next.power_state_field = `PM_DEFAULT;
          mode_next.output_tag_enable = `TAG_DEFAULT;
          mode_next.software_convert_trigger = `SWC_DEFAULT;
          fifo_clear_next = 1'h1;
          full_reset_next = 1'h1;
        end else begin
          // clear code 11 is unused and does nothing
          fifo_clear_next = wr_clear == `CLR_FIFO;
          mode_next.power_state_field = rx_word[`MC_PM_HI:`MC_PM_LO];
          mode_next.software_convert_trigger = rx_word[`MC_SWC_BIT];
          if (!scan_kept) begin
            mode_next.scan_code = wr_scan;
            mode_next.input_channel_number = rx_word[`MC_CHAN_HI:`MC_CHAN_LO];
            mode_next.output_tag_enable = rx_word[`MC_TAG_BIT];
          end
        end
      end else begin
        // the other registers live elsewhere; only pass the word on
        config_write_next = 1'h1;
        config_word_next = rx_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_reg.scan_code <= `SCAN_DEFAULT;
      mode_reg.input_channel_number <= `CHAN_DEFAULT;
      mode_reg.power_state_field <= `PM_DEFAULT;
      mode_reg.output_tag_enable <= `TAG_DEFAULT;
      mode_reg.software_convert_trigger <= `SWC_DEFAULT;
      fifo_clear_reg <= 1'h0;
      full_reset_reg <= 1'h0;
      config_write_reg <= 1'h0;
      config_word_reg <= '0;
    end else begin
      mode_reg <= mode_next;
      fifo_clear_reg <= fifo_clear_next;
      full_reset_reg <= full_reset_next;
      config_write_reg <= config_write_next;
      config_word_reg <= config_word_next;
    end
  end

  // clock mode follows from the scan code alone; the scan plan also uses the channel number
  clock_mode_t clock_mode;
  scan_plan_t scan_plan;

  always_comb begin
    clock_mode = CLOCK_EXTERNAL;
    scan_plan.first_channel = mode_reg.input_channel_number;
    scan_plan.last_channel = mode_reg.input_channel_number;
    scan_plan.fifo_used = 1'h0;
    scan_plan.averaging_ok = 1'h0;
    case (mode_reg.scan_code)
      `SCAN_MANUAL: begin
        clock_mode = CLOCK_EXTERNAL;
      end
      `SCAN_REPEAT: begin
        clock_mode = CLOCK_INTERNAL;
        scan_plan.fifo_used = 1'h1;
        scan_plan.averaging_ok = 1'h1;
      end
      `SCAN_STD_INT: begin
        clock_mode = CLOCK_INTERNAL;
        scan_plan.first_channel = `CHAN_ZERO;
        scan_plan.fifo_used = 1'h1;
        scan_plan.averaging_ok = 1'h1;
      end
      `SCAN_STD_EXT: begin
        scan_plan.first_channel = `CHAN_ZERO;
      end
      `SCAN_UPPER_INT: begin
        clock_mode = CLOCK_INTERNAL;
        scan_plan.last_channel = `CHAN_TOP;
        scan_plan.fifo_used = 1'h1;
        scan_plan.averaging_ok = 1'h1;
      end
      `SCAN_UPPER_EXT: begin
        scan_plan.last_channel = `CHAN_TOP;
      end
      `SCAN_CUSTOM_INT: begin
        clock_mode = CLOCK_INTERNAL;
        scan_plan.fifo_used = 1'h1;
        scan_plan.averaging_ok = 1'h1;
      end
      default: begin
        clock_mode = CLOCK_EXTERNAL;
      end
    endcase
  end

  // conversion start: in internal clock mode either the chip-select rise or
  // the falling edge of the start pin; external clock mode starts nothing here
  always_comb begin
    conv_state_next = conv_state_reg;
    conv_start_next = 1'h0;
    case (conv_state_reg)
      CONV_IDLE: begin
        if (clock_mode == CLOCK_INTERNAL) begin
          if (mode_reg.software_convert_trigger) begin
            conv_start_next = cs_rise;
          end else begin
            conv_start_next = cnv_fall;
          end
        end
        if (conv_start_next) begin
          conv_state_next = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        // a full soft clear also abandons the running conversion
        if (conv_done_i || full_reset_reg) begin
          conv_state_next = CONV_IDLE;
        end
      end
      default: begin
        conv_state_next = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      conv_state_reg <= CONV_IDLE;
      conv_start_reg <= 1'h0;
    end else begin
      conv_state_reg <= conv_state_next;
      conv_start_reg <= conv_start_next;
    end
  end

  // output word format; untagged words put the result in the top 12 bits
  logic tag_effective;
  logic [`MC_WORD_W-1:0] out_word_reg;
  logic [`MC_WORD_W-1:0] out_word_next;
  logic out_valid_reg;
  logic out_valid_next;

  assign tag_effective = mode_reg.output_tag_enable
                         || (clock_mode == CLOCK_INTERNAL);

  always_comb begin
    out_word_next = out_word_reg;
    out_valid_next = result_valid_i;
    if (result_valid_i) begin
      if (tag_effective) begin
        out_word_next = {result_chan_i, result_data_i};
      end else begin
        out_word_next = {result_data_i, `TAG_PAD};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_word_reg <= '0;
      out_valid_reg <= 1'h0;
    end else begin
      out_word_reg <= out_word_next;
      out_valid_reg <= out_valid_next;
    end
  end

  // outputs
  assign mode_o = mode_reg;
  assign clock_mode_o = clock_mode;
  assign output_tag_enable_o = tag_effective;
  assign scan_plan_o = scan_plan;
  assign fifo_clear_o = fifo_clear_reg;
  assign full_reset_o = full_reset_reg;
  assign conv_start_o = conv_start_reg;
  assign conv_busy_o = conv_state_reg == CONV_BUSY;
  assign config_write_o = config_write_reg;
  assign config_word_o = config_word_reg;
  assign out_word_o = out_word_reg;
  assign out_word_valid_o = out_valid_reg;

endmodule : adc_mode_control_decode

// ---- test/serial_host.sv ----
`timescale 1ns/1ps

module serial_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // link clock stands low between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // msb first, data changes while sclk is low; n may be 17 for a convert word
  task automatic send(input logic [15:0] w, input int n);
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_o = (i < 16) ? w[15 - i] : ~din_o;
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #6 cs_n_o = 1'b1;
    din_o = ~din_o; // released line must not keep the last bit
  endtask : send
endmodule : serial_host

// ---- test/mode_decode_monitor.sv ----
`timescale 1ns/1ps
`include "adc_mode_params.svh"

module mode_decode_monitor
  import adc_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic conv_done_i,
  input wire logic result_valid_i,
  input wire logic [`CHAN_W-1:0] result_chan_i,
  input wire logic [`RESULT_W-1:0] result_data_i,
  input mode_ctrl_t mode_o,
  input clock_mode_t clock_mode_o,
  input wire logic output_tag_enable_o,
  input scan_plan_t scan_plan_o,
  input wire logic fifo_clear_o,
  input wire logic full_reset_o,
  input wire logic conv_start_o,
  input wire logic conv_busy_o,
  input wire logic [`MC_WORD_W-1:0] out_word_o,
  input wire logic out_word_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a result is taken, then the formatted word follows one cycle later
  sequence result_in;
    result_valid_i ##1 out_word_valid_o;
  endsequence

  rst_default_a: assert property ($fell(reset_i) |-> mode_o == 12'h100)
    else $error("mode word not at default after reset");
  fmt_word_a: assert property (result_in |-> out_word_o == ($past(output_tag_enable_o) ?
    {$past(result_chan_i), $past(result_data_i)} : {$past(result_data_i), 4'h0}))
    else $error("output word badly formatted");
  tag_or_a: assert property (output_tag_enable_o ==
    (mode_o.output_tag_enable || clock_mode_o == CLOCK_INTERNAL))
    else $error("tag enable wrong");
  clk_mode_a: assert property ((clock_mode_o == CLOCK_INTERNAL) ==
    (mode_o.scan_code inside {4'h2, 4'h3, 4'h5, 4'h7}))
    else $error("clock mode does not follow scan code");
  manual_ext_a: assert property (mode_o.scan_code == 4'h1 |->
    clock_mode_o == CLOCK_EXTERNAL && !scan_plan_o.fifo_used)
    else $error("manual mode not external without fifo");
  repeat_plan_a: assert property (mode_o.scan_code == 4'h2 |-> clock_mode_o == CLOCK_INTERNAL
    && scan_plan_o.first_channel == mode_o.input_channel_number
    && scan_plan_o.last_channel == mode_o.input_channel_number && scan_plan_o.fifo_used)
    else $error("repeat plan wrong");
  std_plan_a: assert property (mode_o.scan_code == 4'h3 |-> clock_mode_o == CLOCK_INTERNAL
    && scan_plan_o.first_channel == 4'h0 && scan_plan_o.fifo_used
    && scan_plan_o.last_channel == mode_o.input_channel_number)
    else $error("standard internal plan wrong");
  full_clr_a: assert property (full_reset_o |-> fifo_clear_o ##[0:1] mode_o == 12'h100)
    else $error("full clear incomplete");
  clr_pulse_a: assert property (fifo_clear_o |=> !fifo_clear_o)
    else $error("fifo clear longer than one cycle");
  start_busy_a: assert property (conv_start_o |-> clock_mode_o == CLOCK_INTERNAL ##1 conv_busy_o)
    else $error("start without busy or in external mode");
  swc_clear_a: assert property (conv_done_i && conv_busy_o && mode_o.software_convert_trigger
    |=> !mode_o.software_convert_trigger && !conv_busy_o)
    else $error("convert bit not cleared after conversion");
endmodule : mode_decode_monitor

bind adc_mode_control_decode mode_decode_monitor i_mode_decode_monitor (.clk_i(clk_i),
  .reset_i(reset_i), .conv_done_i(conv_done_i), .result_valid_i(result_valid_i),
  .result_chan_i(result_chan_i), .result_data_i(result_data_i), .mode_o(mode_o),
  .clock_mode_o(clock_mode_o), .output_tag_enable_o(output_tag_enable_o),
  .scan_plan_o(scan_plan_o), .fifo_clear_o(fifo_clear_o), .full_reset_o(full_reset_o),
  .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o), .out_word_o(out_word_o),
  .out_word_valid_o(out_word_valid_o));

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "adc_mode_params.svh"

module testbench;
  import adc_mode_pkg::*;
  logic clk_i, reset_i, sclk, cs_n, din, cnv_n, done, rvalid, tag, fclr, frst;
  logic cstart, busy, cfg_wr, ow_valid;
  logic [3:0] rchan;
  logic [11:0] rdata;
  logic [15:0] cfg_word, out_word, w;
  mode_ctrl_t mode, exp_m;
  clock_mode_t cmode;
  scan_plan_t plan;
  int fails, check_count, n_fc, n_fr, n_cs, n_cfg, c0, r0, g0, s0;

  adc_mode_control_decode i_adc_mode_control_decode (.clk_i(clk_i), .reset_i(reset_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .convert_start_pin_n_i(cnv_n),
    .conv_done_i(done), .result_valid_i(rvalid), .result_chan_i(rchan),
    .result_data_i(rdata), .mode_o(mode), .clock_mode_o(cmode), .output_tag_enable_o(tag),
    .scan_plan_o(plan), .fifo_clear_o(fclr), .full_reset_o(frst), .conv_start_o(cstart),
    .conv_busy_o(busy), .config_write_o(cfg_wr), .config_word_o(cfg_word),
    .out_word_o(out_word), .out_word_valid_o(ow_valid));
  serial_host i_serial_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // pulse counters, so a one-cycle pulse is never missed between checks
  always @(posedge clk_i) begin
    n_fc <= n_fc + (fclr === 1'b1);
    n_fr <= n_fr + (frst === 1'b1);
    n_cs <= n_cs + (cstart === 1'b1);
    n_cfg <= n_cfg + (cfg_wr === 1'b1);
  end

  // expected mode word after a full 16-bit frame
  function automatic mode_ctrl_t next_m(mode_ctrl_t m, logic [15:0] v);
    next_m = m;
    if (!v[15] && v[6:5] == 2'h2) begin
      next_m = 12'h100; // every field back to default
    end else if (!v[15]) begin
      if (v[14:11] inside {[4'h1:4'h9]}) begin
        next_m.scan_code = v[14:11];
        next_m.input_channel_number = v[10:7];
        next_m.output_tag_enable = v[2];
      end
      next_m.power_state_field = v[4:3];
      next_m.software_convert_trigger = v[1];
    end
  endfunction : next_m

  // expected {clock mode, scan plan}: codes 2, 3, 5 and 7 run on the internal clock
  function automatic logic [10:0] exp_cfg(mode_ctrl_t m);
    logic [3:0] n;
    n = m.input_channel_number;
    case (m.scan_code)
      4'h2: exp_cfg = {1'b1, n, n, 2'h3};
      4'h3: exp_cfg = {1'b1, 4'h0, n, 2'h3};
      4'h4: exp_cfg = {1'b0, 4'h0, n, 2'h0};
      4'h5: exp_cfg = {1'b1, n, 4'hf, 2'h3};
      4'h6: exp_cfg = {1'b0, n, 4'hf, 2'h0};
      4'h7: exp_cfg = {1'b1, n, n, 2'h3};
      default: exp_cfg = {1'b0, n, n, 2'h0};
    endcase
  endfunction : exp_cfg

  task automatic cmp_mode(mode_ctrl_t e);
    check_count++;
    if (mode !== e) begin
      fails++;
      $display("CHECK FAILED %0t mode %h exp %h", $time, mode, e);
    end
  endtask : cmp_mode

  task automatic cmp_word(logic [15:0] g, logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t word %h exp %h", $time, g, e);
    end
  endtask : cmp_word

  task automatic cmp_cnt(int g, int e);
    check_count++;
    if (g != e) begin
      fails++;
      $display("CHECK FAILED %0t count %0d exp %0d", $time, g, e);
    end
  endtask : cmp_cnt

  // one frame, then time for the word to cross into the system clock
  task automatic put(logic [15:0] v, int n);
    i_serial_host.send(v, n);
    repeat (8) @(posedge clk_i);
    #1;
    if (n >= 16) exp_m = next_m(exp_m, v);
  endtask : put

  // drives the pin itself: an output argument would only be copied back at the end
  task automatic pulse;
    @(posedge clk_i);
    cnv_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    cnv_n <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : pulse

  task automatic finish_conv;
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    exp_m.software_convert_trigger = 1'b0;
    cmp_mode(exp_m);
    cmp_word({15'h0, busy}, 16'h0);
  endtask : finish_conv

  task automatic res(logic t);
    logic [3:0] c;
    logic [11:0] d;
    c = 4'($urandom);
    d = 12'($urandom);
    @(posedge clk_i);
    rvalid <= 1'b1;
    rchan <= c;
    rdata <= d;
    @(posedge clk_i);
    rvalid <= 1'b0;
    #1 cmp_word(out_word, t ? {c, d} : {d, 4'h0});
    cmp_word({15'h0, ow_valid}, 16'h1);
  endtask : res

  task automatic stop_test;
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  initial begin
    #400000;
    fails++;
    stop_test();
  end

  initial begin
    {reset_i, cnv_n, done, rvalid, rchan, rdata} = {3'h6, 17'h0};
    {fails, check_count} = '0;
    void'($urandom(32'h5774));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 exp_m = 12'h100;
    cmp_mode(exp_m);
    // random words: scans 0..9 and a reserved code, clears, config words
    for (int k = 0; k < 40; k++) begin
      w = 16'($urandom);
      w[14:11] = (k % 8 == 7) ? 4'hc : w[14:11] % 4'ha;
      w[15] = (k % 5 == 4);
      {c0, r0, g0} = {n_fc, n_fr, n_cfg};
      put(w, 16);
      cmp_mode(exp_m);
      cmp_word({5'h0, cmode, plan}, {5'h0, exp_cfg(exp_m)});
      cmp_cnt(n_fc - c0, !w[15] && w[6:5] inside {2'h1, 2'h2});
      cmp_cnt(n_fr - r0, !w[15] && w[6:5] == 2'h2);
      cmp_cnt(n_cfg - g0, w[15]);
      if (w[15]) cmp_word(cfg_word, w);
    end
    // mid-run reset: a running conversion and all written fields are dropped
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 exp_m = 12'h100;
    cmp_mode(exp_m);
    put(16'h7fff, 9);
    cmp_mode(exp_m);
    put(16'h0040, 16);
    s0 = n_cs;
    put(16'h1282, 17);
    cmp_mode(exp_m);
    cmp_cnt(n_cs - s0, 1);
    cmp_word({15'h0, busy}, 16'h1);
    finish_conv();
    put(16'h0002, 17);
    cmp_cnt(n_cs - s0, 2);
    finish_conv();
    put(16'h1a80, 16);
    pulse();
    cmp_cnt(n_cs - s0, 3);
    finish_conv();
    put(16'h0040, 16);
    put(16'h0802, 17);
    pulse();
    cmp_cnt(n_cs - s0, 3);
    res(1'b0);
    put(16'h0804, 16);
    res(1'b1);
    put(16'h1a80, 16);
    res(1'b1);
    stop_test();
  end
endmodule : testbench
